// ==== logic/btad_pkg.sv ====
// Purpose: Shared constants and types for the bus timeout and address decode block
// Assumes: 125 MHz board clock, 32-bit processor addresses
// Notes:   Every map boundary and timing figure lives here once, except the local device page list decoded in btad_core
`default_nettype none
package btad_pkg;
   // Clock rate
   localparam int unsigned CLK_MHZ           = 125;
   // Local bus timeout choices in microseconds
   localparam int unsigned LTO_8_US          = 8;
   localparam int unsigned LTO_64_US         = 64;
   localparam int unsigned LTO_256_US        = 256;
   // Times in cycles, microseconds times clock MHz, with no rounding or floor
   localparam int unsigned LTO_8_CYC         = LTO_8_US * CLK_MHZ;
   localparam int unsigned LTO_64_CYC        = LTO_64_US * CLK_MHZ;
   localparam int unsigned LTO_256_CYC       = LTO_256_US * CLK_MHZ;
   // Map boundaries
   localparam logic [31:0] DRAM_BASE         = 32'h0000_0000;
   localparam logic [31:0] FLASH_BASE        = 32'hFF80_0000;
   localparam logic [31:0] FLASH_SIZE_DEF    = 32'h0040_0000;
   localparam logic [31:0] UNDEC_LO          = 32'hFFC0_0000;
   localparam logic [31:0] UNDEC_HI          = 32'hFFEF_FFFF;
   localparam logic [31:0] LDEV_LO           = 32'hFFF0_0000;
   localparam logic [31:0] LCL_REG_LO        = 32'hFFF4_0000;
   localparam logic [31:0] LCL_REG_HI        = 32'hFFF4_00FF;
   localparam logic [31:0] GLB_REG_LO        = 32'hFFF4_0100;
   localparam logic [31:0] GLB_REG_HI        = 32'hFFF4_01FF;
   localparam logic [31:0] BOOT_ROM_BASE     = 32'hFFF8_0000;
   localparam logic [31:0] BOOT_ROM_MASK     = 32'h0003_FFFF;
   // Overlay control bit position in the word at address zero
   localparam int unsigned OVL_BIT           = 15;
   // Local timeout select codes
   localparam logic [1:0]  LTO_SEL_8         = 2'h0;
   localparam logic [1:0]  LTO_SEL_64        = 2'h1;
   localparam logic [1:0]  LTO_SEL_256       = 2'h2;
   localparam logic [1:0]  LTO_SEL_INF       = 2'h3;
   // Transfer sizes
   localparam logic [1:0]  SZ_8              = 2'h0;
   localparam logic [1:0]  SZ_16             = 2'h1;
   localparam logic [1:0]  SZ_32             = 2'h2;
   localparam logic [1:0]  SZ_64             = 2'h3;

   // Decoded target of a cycle
   typedef enum logic [2:0] {
      TGT_DRAM, TGT_VME, TGT_FLASH, TGT_UNDEC, TGT_LOCAL, TGT_RSVD, TGT_BOOT
   } btad_tgt_e;

   // Cycle request from the processor bus
   typedef struct packed {
      logic        start;   // First cycle of a data bus tenure
      logic [31:0] addr;    // Byte address
      logic [1:0]  size;    // Transfer size code
      logic        write;   // Write when high
   } btad_req_s;

   // Decode result
   typedef struct packed {
      btad_tgt_e   tgt;     // Target region
      logic        to_lpb;  // Cycle forwarded to the local peripheral bus
      logic [1:0]  port;    // Port width code
   } btad_dec_s;
endpackage
`default_nettype wire

// ==== logic/btad_core.sv ====
// Purpose: Address decode and bus cycle timeout supervision for the processor bus
// Assumes: Processor bus strobes arrive from outside and are synchronised here; address, size, write and data are used directly
// Notes:   One clock; the long local timeout counts are top-level parameters
`default_nettype none
module btad_core
   import btad_pkg::*;
#(
   parameter int unsigned PTO_W        = 16,          // Processor timer period width
   parameter int unsigned LTO_CYC_8    = LTO_8_CYC,   // 8 us in cycles
   parameter int unsigned LTO_CYC_64   = LTO_64_CYC,  // 64 us in cycles
   parameter int unsigned LTO_CYC_256  = LTO_256_CYC  // 256 us in cycles
) (
   input  wire logic              clk_i,               // Board clock
   input  wire logic              rst_n_i,             // Local bus reset, active low
   input  wire logic              data_bus_busy_n_i,   // Bus tenure active, low
   input  wire logic              transfer_ack_n_i,    // Cycle acknowledged, low
   input  wire logic              transfer_retry_n_i,  // Cycle retried, low
   input  wire logic              err_ext_n_i,         // Error ack from another source, low
   input  wire logic [31:0]       addr_i,              // Cycle address
   input  wire logic [1:0]        size_i,              // Transfer size code
   input  wire logic              write_i,             // Write cycle
   input  wire logic [31:0]       wdata_i,             // Write data, overlay bit in 15
   input  wire logic              pto_en_i,            // Processor timer enable
   input  wire logic [PTO_W-1:0]  pto_period_i,        // Processor timeout in cycles
   input  wire logic              lto_en_i,            // Local timer enable
   input  wire logic [1:0]        lto_sel_i,           // Local timeout select
   input  wire logic [31:0]       dram_size_i,         // DRAM decoder size
   input  wire logic [31:0]       flash_size_i,        // Flash decoder size
   output var  btad_pkg::btad_dec_s dec_o,             // Decode of current cycle
   output logic                   transfer_error_ack_n_o, // Error ack, low
   output logic                   boot_overlay_o,      // Boot ROM overlays zero
   output logic                   pto_busy_o,          // Processor timer counting
   output logic                   lto_busy_o           // Local timer counting
);
   import btad_pkg::*;

   // Refuse widths and counts that the timers cannot serve
   if (PTO_W < 2 || PTO_W > 32 || LTO_CYC_8 < 1 || LTO_CYC_64 < 1 || LTO_CYC_256 < 1) begin
      $error("btad_core: bad parameter");
   end

   // Whole module state in one struct
   typedef struct packed {
      logic [2:0]  bsy_s;    // Busy synchroniser plus previous
      logic [1:0]  ack_s;    // Ack synchroniser
      logic [1:0]  rty_s;    // Retry synchroniser
      logic [1:0]  tx_s;     // External error synchroniser
      logic        pto_run;  // Processor timer active
      logic [31:0] pto_cnt;  // Processor timer count
      logic        lto_run;  // Local timer active
      logic [31:0] lto_cnt;  // Local timer count
      logic        err_ack;  // Error ack driven
      logic        ovl;      // Boot overlay
      btad_dec_s   dec;      // Registered decode
   } btad_st_s;

   btad_st_s st_r, st_nxt;

   // Address decode, used for each new tenure
   function automatic btad_dec_s decode(input logic [31:0] a, input logic ovl,
                                        input logic [31:0] dsz, input logic [31:0] fsz);
      btad_dec_s d;
      d = '{tgt: TGT_VME, to_lpb: 1'b0, port: SZ_32};
      if (ovl && a <= BOOT_ROM_MASK) begin
         d = '{tgt: TGT_BOOT, to_lpb: 1'b1, port: SZ_32};
      end else if (a < dsz) begin
         d = '{tgt: TGT_DRAM, to_lpb: 1'b0, port: SZ_64};
      end else if (a >= FLASH_BASE && a < UNDEC_LO && (a - FLASH_BASE) < fsz) begin
         d = '{tgt: TGT_FLASH, to_lpb: 1'b0, port: SZ_32};
      end else if (a >= UNDEC_LO && a <= UNDEC_HI) begin
         d = '{tgt: TGT_UNDEC, to_lpb: 1'b1, port: SZ_32};
      end else if (a >= LDEV_LO) begin
         d = '{tgt: TGT_LOCAL, to_lpb: 1'b1, port: SZ_32};
         if (!known_local(a))
            d = '{tgt: TGT_RSVD, to_lpb: 1'b0, port: SZ_32};
      end
      return d;
   endfunction

   // Local device pages that answer
   function automatic logic known_local(input logic [31:0] a);
      logic [19:0] p;
      p = a[31:12];
      return (p == 20'hFFF00) || (p == 20'hFFF01) || (p == 20'hFFF40) || (p == 20'hFFF42)
          || (p == 20'hFFF44) || (p == 20'hFFF45) || (p == 20'hFFF46) || (p == 20'hFFF47)
          || (a[31:18] == BOOT_ROM_BASE[31:18]) || (a[31:16] == 16'hFFFC);
   endfunction

   // Selected local timeout length
   function automatic logic [31:0] lto_limit(input logic [1:0] s);
      case (s)
         LTO_SEL_8:   return 32'(LTO_CYC_8);
         LTO_SEL_64:  return 32'(LTO_CYC_64);
         LTO_SEL_256: return 32'(LTO_CYC_256);
         default:     return 32'hFFFF_FFFF;
      endcase
   endfunction

   logic        busy;       // Synchronised tenure level
   logic        start;      // First cycle of a tenure
   logic        term_in;    // Outside termination seen
   logic        narrow_lw;  // Narrow local register write
   btad_dec_s   cur;        // Decode of the present address

   // Next state
   always_comb begin
      st_nxt       = st_r;
      st_nxt.bsy_s = {st_r.bsy_s[1:0], ~data_bus_busy_n_i};
      st_nxt.ack_s = {st_r.ack_s[0], ~transfer_ack_n_i};
      st_nxt.rty_s = {st_r.rty_s[0], ~transfer_retry_n_i};
      st_nxt.tx_s  = {st_r.tx_s[0], ~err_ext_n_i};
      busy         = st_r.bsy_s[1];
      start        = st_r.bsy_s[1] && !st_r.bsy_s[2];
      term_in      = st_r.ack_s[1] || st_r.rty_s[1] || st_r.tx_s[1];
      cur          = decode(addr_i, st_r.ovl, dram_size_i, flash_size_i);
      narrow_lw    = write_i && (size_i == SZ_8 || size_i == SZ_16)
                     && addr_i >= LCL_REG_LO && addr_i <= LCL_REG_HI;
      st_nxt.err_ack = 1'b0;
      if (start) begin
         st_nxt.dec     = cur;
         // Timers rearm from zero for each tenure
         st_nxt.pto_cnt = '0;
         st_nxt.lto_cnt = '0;
         st_nxt.pto_run = pto_en_i && !cur.to_lpb;
         st_nxt.lto_run = lto_en_i && cur.to_lpb && lto_sel_i != LTO_SEL_INF;
         st_nxt.err_ack = narrow_lw;
         if (narrow_lw) begin
            st_nxt.pto_run = 1'b0;
            st_nxt.lto_run = 1'b0;
         end
         // Overlay clears on a write at zero with bit 15 low
         if (st_r.ovl && write_i && addr_i == DRAM_BASE && !wdata_i[OVL_BIT])
            st_nxt.ovl = 1'b0;
      end else if (!busy || term_in) begin
         st_nxt.pto_run = 1'b0;
         st_nxt.lto_run = 1'b0;
         st_nxt.pto_cnt = '0;
         st_nxt.lto_cnt = '0;
      end else begin
         if (st_r.pto_run) begin
            st_nxt.pto_cnt = st_r.pto_cnt + 32'h1;
            if (st_r.pto_cnt + 32'h1 >= 32'(pto_period_i)) begin
               st_nxt.err_ack = 1'b1;
               st_nxt.pto_run = 1'b0;
            end
         end
         if (st_r.lto_run) begin
            st_nxt.lto_cnt = st_r.lto_cnt + 32'h1;
            if (st_r.lto_cnt + 32'h1 >= lto_limit(lto_sel_i)) begin
               st_nxt.err_ack = 1'b1;
               st_nxt.lto_run = 1'b0;
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r     <= '0;
         st_r.ovl <= 1'b1;
         st_r.dec <= '{tgt: TGT_VME, to_lpb: 1'b0, port: SZ_32};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dec_o                  = st_r.dec;
   assign transfer_error_ack_n_o = ~st_r.err_ack;
   assign boot_overlay_o         = st_r.ovl;
   assign pto_busy_o             = st_r.pto_run;
   assign lto_busy_o             = st_r.lto_run;

   // Error ack lasts one cycle
   sequence s_err_ack_pulse;
      st_r.err_ack ##1 !st_r.err_ack;
   endsequence

   AST_PTO_NOT_LOCAL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      st_r.dec.to_lpb |-> !st_r.pto_run) else $error("processor timer ran on local cycle");
   AST_PTO_ARMS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (start && pto_en_i && !cur.to_lpb && !narrow_lw) |=> st_r.pto_run)
      else $error("processor timer failed to start");
   AST_PTO_ERR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (st_r.pto_run && busy && !term_in && !start && st_r.pto_cnt + 32'h1 >= 32'(pto_period_i))
      |=> s_err_ack_pulse) else $error("processor timeout gave no error ack");
   AST_PTO_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (!start && (!busy || term_in)) |=> (st_r.pto_cnt == 32'h0 && !st_r.pto_run))
      else $error("processor counter not cleared");
   AST_LTO_INF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (start && lto_sel_i == LTO_SEL_INF) |=> !st_r.lto_run)
      else $error("infinite timeout still counted");
   AST_LTO_ERR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (st_r.lto_run && busy && !term_in && !start
       && st_r.lto_cnt + 32'h1 >= lto_limit(lto_sel_i)) |=> st_r.err_ack)
      else $error("local timeout gave no error ack");
   AST_LTO_NOT_VME: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (st_r.dec.tgt == TGT_VME) |-> !st_r.lto_run) else $error("local timer on VME cycle");
   AST_NARROW_LW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (start && narrow_lw) |=> s_err_ack_pulse) else $error("narrow local write not refused");
   AST_GLB_OK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (start && addr_i >= GLB_REG_LO && addr_i <= GLB_REG_HI) |=> !st_r.err_ack)
      else $error("global register access refused");
   AST_DRAM_DEC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (start && !st_r.ovl && addr_i < dram_size_i) |=> (st_r.dec.tgt == TGT_DRAM
       && st_r.dec.port == SZ_64)) else $error("DRAM decode wrong");
   AST_FLASH_DEC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (start && addr_i >= FLASH_BASE && addr_i < FLASH_BASE + flash_size_i
       && addr_i < UNDEC_LO && addr_i >= dram_size_i) |=> st_r.dec.tgt == TGT_FLASH)
      else $error("flash decode wrong");
   AST_UNDEC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (start && addr_i >= UNDEC_LO && addr_i <= UNDEC_HI && addr_i >= dram_size_i)
      |=> st_r.dec.tgt == TGT_UNDEC) else $error("undecoded range wrong");
   AST_RSVD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (start && addr_i >= LDEV_LO && !known_local(addr_i) && addr_i >= dram_size_i)
      |=> st_r.dec.tgt == TGT_RSVD) else $error("reserved page wrong");
   AST_OVL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (start && st_r.ovl && addr_i <= BOOT_ROM_MASK) |=> st_r.dec.tgt == TGT_BOOT)
      else $error("boot overlay missing");
endmodule
`default_nettype wire

// ==== tb/btad_cpu_model.sv ====
// Purpose: Processor core model that drives bus tenures into the block
// Assumes: One clock; the answering slave is played here as well
// Notes:   Released address and data show inverted values; size and write keep the old ones
`default_nettype none
module btad_cpu_model
   import btad_pkg::*;
(
   input  wire logic        clk_i,     // Board clock
   input  wire logic        err_ack_n_i, // Error ack from the block
   output logic             busy_n_o,  // Tenure active, low
   output logic             ack_n_o,   // Slave ack, low
   output logic             retry_n_o, // Retry, low
   output logic             teax_n_o,  // Foreign error ack, low
   output logic [31:0]      addr_o,    // Cycle address
   output logic [1:0]       size_o,    // Size code
   output logic             write_o,   // Write when high
   output logic [31:0]      wdata_o    // Write data
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial begin
      {busy_n_o, ack_n_o, retry_n_o, teax_n_o} = 4'hF;
      addr_o = 32'h0;
      size_o = SZ_32;
      write_o = 1'b0;
      wdata_o = 32'h0;
   end
   // One tenure; k: 0 late ack, 1 ack, 2 retry, 3 foreign error
   // Lat is edges from busy falling to the error ack, 0 if none
   task automatic run(input logic [31:0] a, input logic [1:0] sz, input logic w,
                      input logic [31:0] wd, input int k, output int lat);
      int term_at;
      int rel_at;
      term_at = (k != 0) ? 3 : 100;
      rel_at = term_at + 1;
      lat = 0;
      @(posedge clk_i);
      busy_n_o <= 1'b0;
      addr_o <= a;
      size_o <= sz;
      write_o <= w;
      wdata_o <= wd;
      for (int i = 1; i <= 120; i++) begin
         @(posedge clk_i);
         // Slave answer, one cycle
         if (i == term_at) begin
            ack_n_o <= (k > 1);
            retry_n_o <= (k != 2);
            teax_n_o <= (k != 3);
         end
         // Release the tenure after it ended
         if (i == rel_at) begin
            {busy_n_o, ack_n_o, retry_n_o, teax_n_o} <= 4'hF;
            addr_o <= ~a;
            wdata_o <= ~wd;
         end
         @(negedge clk_i);
         // Error ack ends the tenure, no slave answer then
         if (lat == 0 && err_ack_n_i === 1'b0) begin
            lat = i;
            if (i < term_at) begin
               term_at = 0;
               rel_at = i + 1;
            end
         end
      end
   endtask
   // Port command as two halfword writes, upper first
   task automatic lan_cmd(input logic [31:0] cmd, output int lat);
      int l2;
      run(32'hFFF4_6000, SZ_16, 1'b1, {16'h0, cmd[31:16]}, 1, lat);
      run(32'hFFF4_6002, SZ_16, 1'b1, {16'h0, cmd[15:0]}, 1, l2);
      lat = lat + l2;
   endtask
   // Overlay is cleared before any DRAM traffic
   task automatic clear_overlay(output int lat);
      run(32'h0, SZ_32, 1'b1, 32'h0, 1, lat);
   endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the decode and timeout block
// Assumes: Local timeouts cut to 10/20/40 cycles, processor period 12
// Notes:   Latency windows allow for the input synchronisers
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import btad_pkg::*;
   typedef struct {
      logic [31:0] a;
      logic [1:0]  sz;
      logic        wr;
      int          kind;
      btad_tgt_e   tgt;
      int          lat;
      logic        pb;
      logic        lb;
   } btad_row_s;
   logic        clk, rst_n, busy_n, ack_n, retry_n, teax_n, wr;
   logic        pto_en, lto_en, err_ack_n, ovl, pbusy, lbusy, pb_seen, lb_seen;
   logic [31:0] addr, wdata, dram_sz, flash_sz;
   logic [1:0]  size, lto_sel;
   logic [15:0] pto_per;
   btad_dec_s   dec;
   int          err_total, tests_run, lat;
   int          sel_lat [4] = '{10, 20, 40, 0};
   // Address, size, write, answer, target, latency, timers seen
   btad_row_s   rows [15] = '{
      '{32'h0000_0100, SZ_64, 0, 1, TGT_DRAM, 0, 1, 0},
      '{32'h00FF_FFF8, SZ_64, 1, 0, TGT_DRAM, 12, 1, 0},
      '{32'h0100_0000, SZ_32, 0, 0, TGT_VME, 12, 1, 0},
      '{32'hFF80_0000, SZ_32, 0, 1, TGT_FLASH, 0, 1, 0},
      '{32'hFFBF_FFFC, SZ_32, 1, 2, TGT_FLASH, 0, 1, 0},
      '{32'hFFC0_0000, SZ_32, 0, 0, TGT_UNDEC, 10, 0, 1},
      '{32'hFFF0_2000, SZ_32, 0, 0, TGT_RSVD, 12, 1, 0},
      '{32'hFFF4_0000, SZ_8, 1, 0, TGT_LOCAL, 1, 0, 0},
      '{32'hFFF4_00FE, SZ_16, 1, 0, TGT_LOCAL, 1, 0, 0},
      '{32'hFFF4_0004, SZ_32, 1, 1, TGT_LOCAL, 0, 0, 1},
      '{32'hFFF4_0100, SZ_8, 1, 1, TGT_LOCAL, 0, 0, 1},
      '{32'hFFF4_0000, SZ_8, 0, 1, TGT_LOCAL, 0, 0, 1},
      '{32'hFFF4_0010, SZ_16, 0, 0, TGT_LOCAL, 10, 0, 1},
      '{32'hFFF8_0000, SZ_32, 0, 0, TGT_LOCAL, 10, 0, 1},
      '{32'h0000_0200, SZ_64, 1, 3, TGT_DRAM, 0, 1, 0}};

   btad_core #(.LTO_CYC_8(10), .LTO_CYC_64(20), .LTO_CYC_256(40)) i_btad_core (
      .clk_i(clk), .rst_n_i(rst_n), .data_bus_busy_n_i(busy_n),
      .transfer_ack_n_i(ack_n), .transfer_retry_n_i(retry_n), .err_ext_n_i(teax_n),
      .addr_i(addr), .size_i(size), .write_i(wr), .wdata_i(wdata),
      .pto_en_i(pto_en), .pto_period_i(pto_per), .lto_en_i(lto_en),
      .lto_sel_i(lto_sel), .dram_size_i(dram_sz), .flash_size_i(flash_sz),
      .dec_o(dec), .transfer_error_ack_n_o(err_ack_n), .boot_overlay_o(ovl),
      .pto_busy_o(pbusy), .lto_busy_o(lbusy));
   btad_cpu_model i_btad_cpu_model (
      .clk_i(clk), .err_ack_n_i(err_ack_n), .busy_n_o(busy_n), .ack_n_o(ack_n),
      .retry_n_o(retry_n), .teax_n_o(teax_n), .addr_o(addr), .size_o(size),
      .write_o(wr), .wdata_o(wdata));

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Remember which timer ran during a tenure
   always @(negedge clk) begin
      if (pbusy === 1'b1) pb_seen = 1'b1;
      if (lbusy === 1'b1) lb_seen = 1'b1;
   end
   task automatic chk_bit(input string nm, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_tgt(input string nm, input btad_tgt_e e, input logic [2:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic chk_port(input string nm, input logic [1:0] e, input logic [1:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   // Port width the map gives each target: DRAM is 64 bits, the rest 32
   function automatic logic [1:0] exp_port(input btad_tgt_e t);
      return (t == TGT_DRAM) ? SZ_64 : SZ_32;
   endfunction
   // Zero means no error ack; else the ack lands within six edges of it
   task automatic chk_lat(input string nm, input int e, input int g);
      tests_run++;
      if ((e == 0) ? (g != 0) : (g < e || g > e + 6)) begin
         err_total++;
         $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic go(input logic [31:0] a, input logic [1:0] sz, input logic w,
                     input logic [31:0] wd, input int k);
      pb_seen = 1'b0;
      lb_seen = 1'b0;
      i_btad_cpu_model.run(a, sz, w, wd, k, lat);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog well beyond the expected run time
   initial begin
      #400000;
      err_total++;
      $display("[FAIL] watchdog expected end seen hang");
      close_out();
   end
   // Main sequence
   initial begin
      rst_n = 1'b0;
      {pto_en, lto_en} = 2'h3;
      lto_sel = LTO_SEL_8;
      pto_per = 16'h000C;
      dram_sz = 32'h0100_0000;
      flash_sz = FLASH_SIZE_DEF;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk_bit("reset error ack", 1'b1, err_ack_n);
      chk_bit("reset overlay", 1'b1, ovl);
      // Boot ROM at zero until the overlay bit is written low
      go(32'h0, SZ_32, 1'b0, 32'hFFFF_FFFF, 1);
      chk_tgt("zero boot", TGT_BOOT, dec.tgt);
      go(32'h0, SZ_32, 1'b1, 32'h0000_8000, 1);
      chk_bit("overlay kept", 1'b1, ovl);
      i_btad_cpu_model.clear_overlay(lat);
      chk_bit("overlay off", 1'b0, ovl);
      foreach (rows[n]) begin
         go(rows[n].a, rows[n].sz, rows[n].wr, 32'hFFFF_FFFF, rows[n].kind);
         chk_tgt($sformatf("row %0d tgt", n), rows[n].tgt, dec.tgt);
         chk_port($sformatf("row %0d port", n), exp_port(rows[n].tgt), dec.port);
         chk_lat($sformatf("row %0d lat", n), rows[n].lat, lat);
         chk_bit($sformatf("row %0d pto", n), rows[n].pb, pb_seen);
         chk_bit($sformatf("row %0d lto", n), rows[n].lb, lb_seen);
      end
      // Every local timeout select, infinite gives none
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         lto_sel <= 2'(s);
         go(32'hFFC0_0000, SZ_32, 1'b0, 32'hFFFF_FFFF, 0);
         chk_lat($sformatf("select %0d", s), sel_lat[s], lat);
      end
      // Timers disabled: unanswered cycles stay open
      @(posedge clk);
      {pto_en, lto_en} <= 2'h0;
      lto_sel <= LTO_SEL_8;
      go(32'h0000_0400, SZ_64, 1'b0, 32'hFFFF_FFFF, 0);
      chk_lat("pto off", 0, lat);
      go(32'hFFC0_0000, SZ_32, 1'b0, 32'hFFFF_FFFF, 0);
      chk_lat("lto off", 0, lat);
      @(posedge clk);
      {pto_en, lto_en} <= 2'h3;
      i_btad_cpu_model.lan_cmd(32'h1234_5678, lat);
      chk_lat("lan halfwords", 0, lat);
      // Smaller decoders hand the space above them to VMEbus
      @(posedge clk);
      dram_sz <= 32'h0080_0000;
      flash_sz <= 32'h0010_0000;
      go(32'h007F_FFF8, SZ_64, 1'b0, 32'hFFFF_FFFF, 1);
      chk_tgt("dram size in", TGT_DRAM, dec.tgt);
      go(32'h00FF_FFF8, SZ_64, 1'b0, 32'hFFFF_FFFF, 1);
      chk_tgt("dram size out", TGT_VME, dec.tgt);
      go(32'hFF8F_FFFC, SZ_32, 1'b0, 32'hFFFF_FFFF, 1);
      chk_tgt("flash size in", TGT_FLASH, dec.tgt);
      go(32'hFF90_0000, SZ_32, 1'b0, 32'hFFFF_FFFF, 1);
      chk_tgt("flash size out", TGT_VME, dec.tgt);
      // A second reset brings the overlay back
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk_bit("overlay again", 1'b1, ovl);
      close_out();
   end
endmodule
`default_nettype wire
